// *** src/dsd_cfg.svh ***
// Summary of operation
// - Normal map: regs, std I/O, ext I/O, SRAM.
// - Compat map: regs, std I/O, 4000 SRAM.
// - Extended I/O only via data-space access.
// - External region follows last internal address.
// - High addresses go to external memory.
// - Internal accesses keep external strobes inactive.
// - External access needs ext_mem_enable set.
// - Zero wait: one extra cycle per byte.
// - Wait states 1..3 add 2..4 cycles.
// - External stack call/return: two extra cycles.
// - External stack with waits: 4,6,8 extra.
// - Internal SRAM access takes two cycles.
// - Displacement adds up to 63 to Y/Z.
// - Pre-decrement/post-increment updates the pointer.
`ifndef DSD_CFG_SVH
`define DSD_CFG_SVH
`define DSD_REG_END 16'h0020
`define DSD_STDIO_END 16'h0060
`define DSD_EXTIO_END 16'h0100
`define DSD_INT_END_NORM 16'h1100
`define DSD_INT_END_COMPAT 16'h1000
`define DSD_INT_CYCLES 3'h2
`define DSD_DISP_MAX 6'h3F
`endif

// *** src/dsd_pkg.sv ***
package dsd_pkg;
	typedef enum logic [2:0] {DSD_REG, DSD_STDIO, DSD_EXTIO, DSD_SRAM, DSD_EXT, DSD_NONE} dsd_region_t;
	typedef enum logic [1:0] {DSD_AM_DIRECT, DSD_AM_DISP, DSD_AM_PREDEC, DSD_AM_POSTINC} dsd_amode_t;
	typedef enum logic [1:0] {DSD_OP_DATA, DSD_OP_IO, DSD_OP_STACK2} dsd_op_t;
endpackage

// *** src/dsd_ext_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface dsd_ext_if;
	logic start;
	logic is_write;
	logic [1:0] waits;
	logic busy;
	logic rd_strobe;
	logic wr_strobe;
	modport ctl (output start, output is_write, output waits, input busy, input rd_strobe, input wr_strobe);
	modport seq (input start, input is_write, input waits, output busy, output rd_strobe, output wr_strobe);
endinterface
`default_nettype wire

// *** src/dsd_ext_seq.sv ***
`timescale 1ns/10ps
`default_nettype none
module dsd_ext_seq (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	dsd_ext_if.seq bus
);
	logic [2:0] cnt;
	logic wr;
	logic [2:0] next_cnt;
	// Each byte holds the strobe for base plus one extra cycle, plus one more per wait state.
	assign next_cnt = bus.waits == 2'h0 ? 3'h3 : 3'(bus.waits) + 3'h3;
	// Counter runs the external byte cycle and the strobe follows it.
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt <= 3'h0;
			wr <= 1'b0;
		end else if (bus.start && cnt == 3'h0) begin
			cnt <= next_cnt;
			wr <= bus.is_write;
		end else if (cnt != 3'h0) begin
			cnt <= cnt - 3'h1;
		end
	end
	assign bus.busy = cnt != 3'h0;
	assign bus.rd_strobe = bus.busy && !wr;
	assign bus.wr_strobe = bus.busy && wr;
endmodule
`default_nettype wire

// *** src/dsd_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "dsd_cfg.svh"
module dsd_top (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_req,
	input wire logic i_write,
	input wire logic [1:0] i_op,
	input wire logic [1:0] i_amode,
	input wire logic [15:0] i_base,
	input wire logic [5:0] i_disp,
	input wire logic i_compat,
	input wire logic i_ext_mem_enable,
	input wire logic [1:0] i_wait_states,
	output logic o_busy,
	output logic o_done,
	output logic [2:0] o_region,
	output logic [15:0] o_addr,
	output logic [15:0] o_ptr_next,
	output logic o_ptr_we,
	output logic o_write_strobe_pin,
	output logic o_read_strobe_pin
);
	dsd_ext_if ext ();
	logic [15:0] eff_addr;
	logic [15:0] int_end;
	dsd_pkg::dsd_region_t region;
	logic go_ext;
	logic [2:0] cyc;
	logic [1:0] bytes_left;
	logic wr_q;
	dsd_pkg::dsd_region_t region_q;
	// Effective address by mode; displacement only ever adds 0..63.
	assign eff_addr = i_amode == 2'(dsd_pkg::DSD_AM_DISP) ? i_base + {10'h000, i_disp & `DSD_DISP_MAX} :
		i_amode == 2'(dsd_pkg::DSD_AM_PREDEC) ? i_base - 16'h0001 : i_base;
	assign int_end = i_compat ? `DSD_INT_END_COMPAT : `DSD_INT_END_NORM;
	// Region decode; compat mode has no extended I/O so that range is SRAM.
	assign region = eff_addr < `DSD_REG_END ? dsd_pkg::DSD_REG :
		eff_addr < `DSD_STDIO_END ? dsd_pkg::DSD_STDIO :
		(eff_addr < `DSD_EXTIO_END && !i_compat) ? dsd_pkg::DSD_EXTIO :
		eff_addr < int_end ? dsd_pkg::DSD_SRAM :
		i_ext_mem_enable ? dsd_pkg::DSD_EXT : dsd_pkg::DSD_NONE;
	assign go_ext = i_req && !o_busy && region == dsd_pkg::DSD_EXT && i_op != 2'(dsd_pkg::DSD_OP_IO);
	assign ext.waits = i_wait_states;
	assign ext.is_write = wr_q;
	// A new external byte starts once the sequencer is idle and bytes remain.
	assign ext.start = o_busy && region_q == dsd_pkg::DSD_EXT && !ext.busy && bytes_left != 2'h0;
	// The sequencer owns the per-byte strobe timing.
	dsd_ext_seq u_seq (
		.i_ref_clk(i_ref_clk),
		.i_nrst(i_nrst),
		.bus(ext)
	);
	// Access sequencing: internal takes two cycles, external one byte per sequencer run.
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_region <= 3'h5;
			region_q <= dsd_pkg::DSD_NONE;
			o_addr <= 16'h0000;
			o_ptr_next <= 16'h0000;
			o_ptr_we <= 1'b0;
			cyc <= 3'h0;
			bytes_left <= 2'h0;
			wr_q <= 1'b0;
		end else if (i_req && !o_busy && !(i_op == 2'(dsd_pkg::DSD_OP_IO) && eff_addr >= `DSD_STDIO_END)) begin
			o_busy <= 1'b1;
			o_done <= 1'b0;
			o_region <= 3'(region);
			region_q <= region;
			o_addr <= eff_addr;
			o_ptr_next <= i_amode == 2'(dsd_pkg::DSD_AM_POSTINC) ? i_base + 16'h0001 : eff_addr;
			o_ptr_we <= i_amode == 2'(dsd_pkg::DSD_AM_POSTINC) || i_amode == 2'(dsd_pkg::DSD_AM_PREDEC);
			cyc <= `DSD_INT_CYCLES - 3'h1;
			bytes_left <= go_ext ? (i_op == 2'(dsd_pkg::DSD_OP_STACK2) ? 2'h2 : 2'h1) : 2'h0;
			wr_q <= i_write;
		end else begin
			o_ptr_we <= 1'b0;
			o_done <= 1'b0;
			if (ext.start) begin
				bytes_left <= bytes_left - 2'h1;
			end
			if (o_busy && region_q != dsd_pkg::DSD_EXT) begin
				cyc <= cyc - 3'h1;
				if (cyc == 3'h1) begin
					o_busy <= 1'b0;
					o_done <= 1'b1;
				end
			end else if (o_busy && bytes_left == 2'h0 && !ext.busy && !ext.start) begin
				o_busy <= 1'b0;
				o_done <= 1'b1;
			end
		end
	end
	// Strobes registered; only external-region accesses ever raise them.
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_read_strobe_pin <= 1'b0;
			o_write_strobe_pin <= 1'b0;
		end else begin
			o_read_strobe_pin <= ext.rd_strobe;
			o_write_strobe_pin <= ext.wr_strobe;
		end
	end
	sequence int_start_s;
		i_req && !o_busy && region != dsd_pkg::DSD_EXT && i_op != 2'(dsd_pkg::DSD_OP_IO);
	endsequence
	int_two_cyc_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) int_start_s |=> ##1 o_done)
		else $error("internal access did not finish in two cycles");
	int_no_strobe_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		o_busy && region_q != dsd_pkg::DSD_EXT |-> !ext.rd_strobe && !ext.wr_strobe)
		else $error("strobe during internal access");
	dis_no_ext_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		!i_ext_mem_enable && i_req && !o_busy |-> region != dsd_pkg::DSD_EXT)
		else $error("external region while disabled");
	compat_map_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		i_compat && eff_addr >= 16'h0060 && eff_addr < 16'h1000 |-> region == dsd_pkg::DSD_SRAM)
		else $error("compat map wrong");
	norm_map_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		!i_compat && eff_addr >= 16'h0060 && eff_addr < 16'h0100 |-> region == dsd_pkg::DSD_EXTIO)
		else $error("ext io map wrong");
	ext_above_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		i_ext_mem_enable && !i_compat && eff_addr >= 16'h1100 |-> region == dsd_pkg::DSD_EXT)
		else $error("external start wrong");
	zero_wait_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		ext.start && ext.waits == 2'h0 |=> ext.busy [*3] ##1 !ext.busy)
		else $error("zero wait length wrong");
	postinc_ptr_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		i_req && !o_busy && i_amode == 2'(dsd_pkg::DSD_AM_POSTINC) && i_op != 2'(dsd_pkg::DSD_OP_IO)
		|=> o_ptr_we && o_ptr_next == $past(i_base) + 16'h0001)
		else $error("post increment wrong");
	// Take of a one-byte external data access with no wait states.
	sequence take_ext_zero_s;
		i_req && !o_busy && region == dsd_pkg::DSD_EXT && i_op == 2'(dsd_pkg::DSD_OP_DATA) && i_wait_states == 2'h0;
	endsequence
	// Take of a two-byte external stack access with no wait states.
	sequence take_stack_zero_s;
		i_req && !o_busy && region == dsd_pkg::DSD_EXT && i_op == 2'(dsd_pkg::DSD_OP_STACK2) && i_wait_states == 2'h0;
	endsequence
	// Take of a two-byte external stack access with one wait state.
	sequence take_stack_one_s;
		i_req && !o_busy && region == dsd_pkg::DSD_EXT && i_op == 2'(dsd_pkg::DSD_OP_STACK2) && i_wait_states == 2'h1;
	endsequence
	// A single external byte ends four cycles later than an internal access.
	ext_one_byte_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) take_ext_zero_s |=> ##5 o_done)
		else $error("external byte length wrong");
	// Two stacked bytes with no wait states.
	stack_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) take_stack_zero_s |=> ##9 o_done)
		else $error("external stack length wrong");
	// Two stacked bytes with one wait state each.
	stack_wait_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) take_stack_one_s |=> ##11 o_done)
		else $error("external stack with wait wrong");
	// One wait state stretches the byte by one more cycle.
	wait_one_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		ext.start && ext.waits == 2'h1 |=> ext.busy [*4] ##1 !ext.busy)
		else $error("one wait length wrong");
	// Two wait states stretch the byte by two more cycles.
	wait_two_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		ext.start && ext.waits == 2'h2 |=> ext.busy [*5] ##1 !ext.busy)
		else $error("two wait length wrong");
	// Three wait states stretch the byte by three more cycles.
	wait_three_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		ext.start && ext.waits == 2'h3 |=> ext.busy [*6] ##1 !ext.busy)
		else $error("three wait length wrong");
	// Short I/O instructions never reach beyond the standard I/O area.
	io_refused_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		i_req && !o_busy && i_op == 2'(dsd_pkg::DSD_OP_IO) && eff_addr >= 16'h0060 |=> !o_busy)
		else $error("short io beyond range taken");
	// Compatibility mode has no extended I/O region.
	compat_no_extio_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		i_compat |-> region != dsd_pkg::DSD_EXTIO)
		else $error("extended io in compat map");
	// Displacement is added to the base pointer.
	disp_add_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		i_req && !o_busy && i_amode == 2'(dsd_pkg::DSD_AM_DISP) && i_op != 2'(dsd_pkg::DSD_OP_IO)
		|=> o_addr == $past(i_base) + {10'h000, $past(i_disp)})
		else $error("displacement wrong");
	// Pre-decrement writes back the lowered pointer.
	predec_ptr_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		i_req && !o_busy && i_amode == 2'(dsd_pkg::DSD_AM_PREDEC) && i_op != 2'(dsd_pkg::DSD_OP_IO)
		|=> o_ptr_we && o_ptr_next == $past(i_base) - 16'h0001)
		else $error("pre decrement wrong");
	// The pins stay low for the whole of an internal access.
	int_pin_low_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		o_busy && region_q != dsd_pkg::DSD_EXT |-> !o_read_strobe_pin && !o_write_strobe_pin)
		else $error("pin strobe during internal access");
	// A disabled external region never runs the sequencer.
	none_no_ext_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		o_busy && region_q == dsd_pkg::DSD_NONE |-> !ext.busy)
		else $error("sequencer ran while disabled");
	// A raised pin always belongs to an external access.
	pin_ext_only_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		o_read_strobe_pin || o_write_strobe_pin |-> region_q == dsd_pkg::DSD_EXT)
		else $error("pin strobe outside external region");
	// Read and write strobes never show together.
	strobe_excl_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		!(o_read_strobe_pin && o_write_strobe_pin))
		else $error("both strobes active");
	// Completion is a single-cycle pulse.
	done_pulse_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		o_done |=> !o_done)
		else $error("done longer than one cycle");
	// The pointer write is a single-cycle pulse.
	ptr_pulse_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		o_ptr_we |=> !o_ptr_we)
		else $error("pointer write longer than one cycle");
endmodule
`default_nettype wire

// *** tb/dsd_sram_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// External memory stand-in: it counts the cycles in which either strobe is active.
module dsd_sram_model (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_rd,
	input wire logic i_wr,
	output int o_cycles
);
	// A bench that snapshots the count before each access can tell whether the access went off chip.
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_cycles <= 0;
		end else if (i_rd || i_wr) begin
			o_cycles <= o_cycles + 1;
		end
	end
endmodule
`default_nettype wire

// *** tb/dsd_top_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module dsd_top_bench;
	logic clk = 0, nrst = 0, req = 0, wr = 0, cmp = 0, en = 0, done_seen = 0, we_seen = 0;
	logic [1:0] op = 0, am = 0, ws = 0;
	logic [15:0] base = 0;
	logic [5:0] disp = 0;
	logic busy, done, ptr_we, wstb, rstb;
	logic [2:0] region;
	logic [15:0] addr, ptr;
	logic [43:0] notes[$];
	int cyc, start, fail_count = 0, n_tests = 0, cycles = 0;
	logic [15:0] pts[10] = '{16'h001F, 16'h0020, 16'h005F, 16'h0060, 16'h00FF, 16'h0100, 16'h0FFF, 16'h1000,
		16'h10FF, 16'h1100};
	dsd_top dsd_top_inst (.i_ref_clk(clk), .i_nrst(nrst), .i_req(req), .i_write(wr), .i_op(op), .i_amode(am),
		.i_base(base), .i_disp(disp), .i_compat(cmp), .i_ext_mem_enable(en), .i_wait_states(ws), .o_busy(busy),
		.o_done(done), .o_region(region), .o_addr(addr), .o_ptr_next(ptr), .o_ptr_we(ptr_we),
		.o_write_strobe_pin(wstb), .o_read_strobe_pin(rstb));
	dsd_sram_model dsd_sram_model_inst (.i_ref_clk(clk), .i_nrst(nrst), .i_rd(rstb), .i_wr(wstb), .o_cycles(cyc));
	// Clock of 5 ns period.
	initial begin
		forever #2.5 clk = ~clk;
	end
	// Expected region from the address and the map mode.
	function automatic logic [2:0] exp_region(logic [15:0] a, logic c, logic e);
		if (a < 16'h0020) return 3'h0;
		if (a < 16'h0060) return 3'h1;
		if (!c && a < 16'h0100) return 3'h2;
		if (a < (c ? 16'h1000 : 16'h1100)) return 3'h3;
		return e ? 3'h4 : 3'h5;
	endfunction
	// Prints the verdict and stops the run.
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// One data access; the expected outcome is queued before the request goes out.
	task automatic access(logic [15:0] b, logic [5:0] d, logic [1:0] m, logic [1:0] o = 2'h0);
		logic [15:0] a, p;
		logic [7:0] n;
		a = (m == 2'h1) ? b + {10'h000, d} : (m == 2'h2) ? b - 16'h0001 : b;
		p = (m == 2'h2) ? b - 16'h0001 : b + 16'h0001;
		@(posedge clk);
		n = (exp_region(a, cmp, en) == 3'h4) ? ((o == 2'h2) ? 8'h02 : 8'h01) * (8'h03 + 8'(ws)) : 8'h00;
		start = cyc;
		done_seen = 0;
		we_seen = 0;
		notes.push_back({m[1], n, exp_region(a, cmp, en), a, (m[1] ? p : 16'h0000)});
		req <= 1;
		op <= o;
		wr <= 1'($urandom);
		base <= b;
		disp <= d;
		am <= m;
		@(posedge clk);
		req <= 0;
		repeat (200) if (!done_seen) @(posedge clk);
		if (!done_seen) fail_count++;
	endtask
	// A short I/O request beyond the standard area must be ignored.
	task automatic io_refused(logic [15:0] b);
		@(posedge clk);
		op <= 2'h1;
		am <= 2'h0;
		base <= b;
		req <= 1;
		@(posedge clk);
		req <= 0;
		@(posedge clk);
		n_tests++;
		if (busy !== 1'b0) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, busy, 1'b0);
		end
		op <= 2'h0;
	endtask
	// Oldest note is compared whenever a completion shows; region, address, pointer and strobe use.
	always @(negedge clk) begin
		logic [43:0] e;
		if (ptr_we === 1'b1) we_seen = 1;
		if (done === 1'b1 && notes.size() > 0) begin
			e = notes.pop_front();
			n_tests++;
			if ({we_seen, 8'(cyc - start), region, addr, (e[43] ? ptr : 16'h0000)} !== e || busy !== 1'b0) begin
				fail_count++;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, {we_seen, 8'(cyc - start), region, addr, ptr}, e);
			end
			done_seen = 1;
		end
	end
	// Hang guard.
	initial begin
		forever begin
			@(posedge clk);
			cycles++;
			if (cycles > 20000) begin
				fail_count++;
				complete_run();
			end
		end
	end
	// Boundary sweep over both maps, external enable on and off, every mode and wait count.
	initial begin
		void'($urandom(2));
		repeat (2) @(posedge clk);
		nrst <= 1;
		for (int c = 0; c < 4; c++) begin
			cmp <= c[0];
			en <= c[1];
			for (int i = 0; i < 10; i++) begin
				ws <= i[1:0];
				access(pts[i], 6'h3F, 2'h0);
				access(pts[i], 6'h00, 2'h2);
				access(pts[i], 6'h00, 2'h3);
				access(pts[i] - 16'h003F, 6'h3F, 2'h1);
				access(16'($urandom_range(16'hFFFF, 0)), 6'($urandom), 2'h0);
			end
			$display("Test map %0d done", c);
		end
		cmp <= 0;
		en <= 1;
		for (int w = 0; w < 2; w++) begin
			ws <= w[1:0];
			access(16'h2000, 6'h00, 2'h2, 2'h2);
		end
		access(16'h0040, 6'h00, 2'h0, 2'h1);
		io_refused(16'h0080);
		$display("Test stack and I/O done");
		repeat (4) @(posedge clk);
		complete_run();
	end
endmodule
`default_nettype wire
